// ===== common/dcet_pkg.sv
// constants and types for the dma channel event trigger block
// Overview of operation
// - bits 23:16 hold an 8-bit abort irq select naming one of 256 irq lines.
// - a selected abort irq with abort triggering on aborts the transfer and sets the abort flag.
// - bits 15:8 hold an 8-bit start irq select naming irq 0 to 255.
// - with start irq enable (bit 4) set, each matching irq starts a cell transfer unless an abort falls in the same cycle.
// - with start irq enable clear, the selected start irq starts nothing.
// - with abort irq enable (bit 3) set, each matching irq aborts the transfer.
// - with abort irq enable clear, the selected abort irq aborts nothing.
// - writing one to bit 7 through the word, set or invert offset forces a transfer start unless an abort falls in the same cycle; the bit reads as zero.
// - writing one to bit 6 through the word, set or invert offset aborts the transfer; the bit reads as zero.
// - with pattern abort enable (bit 5) set, a pattern match aborts and clears channel enable.
// - with pattern abort enable clear, a pattern match has no effect.
// - bits 31:24 and 2:0 read as zero and ignore writes.
// - clear, set and invert aliases sit at offsets 0x4, 0x8 and 0xC.
package dcet_pkg;

  localparam int unsigned DCET_ADDR_W = 8;
  localparam int unsigned DCET_IRQ_N  = 256;

  // register offsets of the control word, its aliases, the channel control word and status
  localparam logic [7:0] DCET_OFF_ECON = 8'h00;
  localparam logic [7:0] DCET_OFF_CLR  = 8'h04;
  localparam logic [7:0] DCET_OFF_SET  = 8'h08;
  localparam logic [7:0] DCET_OFF_INV  = 8'h0C;
  localparam logic [7:0] DCET_OFF_CON  = 8'h10;
  localparam logic [7:0] DCET_OFF_STAT = 8'h20;

  // field positions
  localparam int unsigned DCET_AIRQ_LSB   = 16;
  localparam int unsigned DCET_SIRQ_LSB   = 8;
  localparam int unsigned DCET_FORCE_BIT  = 7;
  localparam int unsigned DCET_ABORT_BIT  = 6;
  localparam int unsigned DCET_PATTERN_ABORT_ENABLE_BIT  = 5;
  localparam int unsigned DCET_START_IRQ_ENABLE_BIT = 4;
  localparam int unsigned DCET_ABORT_IRQ_ENABLE_BIT = 3;
  localparam int unsigned DCET_CHANNEL_ENABLE_BIT   = 7;
  localparam int unsigned DCET_FLAG_BIT   = 0;
  localparam int unsigned DCET_BUSY_BIT   = 1;

  // writable bits of the control word
  localparam logic [31:0] DCET_ECON_MASK  = 32'h00FF_FF38;
  localparam logic [31:0] DCET_ECON_RESET = 32'h00FF_FF00;

  typedef struct packed {
    logic [DCET_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
  } dcet_bus_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic pattern_abort;
  } dcet_cmd_t;

  typedef enum logic [1:0] {
    DCET_IDLE = 2'b00,
    DCET_BUSY = 2'b01
  } dcet_state_t;

endpackage : dcet_pkg

// ===== hdl/dcet_irq_match.sv
// irq line matcher: registered detection of one selected irq line
`timescale 1ns/1ps
`default_nettype none
module dcet_irq_match
  import dcet_pkg::*;
#(
  parameter int unsigned IRQ_N = 256
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [IRQ_N-1:0] irq_sync,
  input  wire logic [7:0]       select,
  input  wire logic             enable,
  output logic                  hit
);

  // rising edge detect so a held irq triggers once, not every cycle
  logic [IRQ_N-1:0] irq_prev;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_prev <= '0;
      hit      <= 1'b0;
    end else begin
      irq_prev <= irq_sync;
      hit      <= enable && irq_sync[select] && !irq_prev[select];
    end
  end

endmodule : dcet_irq_match
`default_nettype wire

// ===== hdl/dcet_top.sv
// dma channel event trigger: control register, irq triggers, start/abort
`timescale 1ns/1ps
`default_nettype none
module dcet_top
  import dcet_pkg::*;
#(
  parameter int unsigned IRQ_N = DCET_IRQ_N
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic [DCET_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [31:0]            rdata,
  input  wire logic [IRQ_N-1:0]       irq_lines,
  input  wire logic                   pattern_match,
  input  wire logic                   transfer_done,
  output logic                        xfer_start,
  output logic                        xfer_abort,
  output logic                        channel_enable,
  output logic                        channel_abort_flag
);

  // control word fields
  logic [7:0] abort_irq_select;
  logic [7:0] start_irq_select;
  logic       pattern_abort_enable;
  logic       start_irq_enable;
  logic       abort_irq_enable;

  dcet_bus_t   bus;
  dcet_cmd_t   cmd;
  dcet_state_t state;

  logic [IRQ_N-1:0] irq_meta;
  logic [IRQ_N-1:0] irq_sync;
  logic             pat_meta;
  logic             pat_sync;
  logic             done_meta;
  logic             done_sync;
  logic             start_hit;
  logic             abort_hit;
  logic             force_pulse;
  logic             swabort_pulse;
  logic [31:0]      econ;
  logic [31:0]      next_econ;
  logic             econ_wr;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // two-flop synchronisers for pins from outside the clock domain
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_meta  <= '0;
      irq_sync  <= '0;
      pat_meta  <= 1'b0;
      pat_sync  <= 1'b0;
      done_meta <= 1'b0;
      done_sync <= 1'b0;
    end else begin
      irq_meta  <= irq_lines;
      irq_sync  <= irq_meta;
      pat_meta  <= pattern_match;
      pat_sync  <= pat_meta;
      done_meta <= transfer_done;
      done_sync <= done_meta;
    end
  end

  // one matcher per trigger; the enable gates the hit at the source
  dcet_irq_match #(
    .IRQ_N (IRQ_N)
  ) u_start_match (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .irq_sync (irq_sync),
    .select   (start_irq_select),
    .enable   (start_irq_enable),
    .hit      (start_hit)
  );

  dcet_irq_match #(
    .IRQ_N (IRQ_N)
  ) u_abort_match (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .irq_sync (irq_sync),
    .select   (abort_irq_select),
    .enable   (abort_irq_enable),
    .hit      (abort_hit)
  );

  // assemble readable control word; force and abort bits read zero
  always_comb begin
    econ = '0;
    econ[DCET_AIRQ_LSB +: 8] = abort_irq_select;
    econ[DCET_SIRQ_LSB +: 8] = start_irq_select;
    econ[DCET_PATTERN_ABORT_ENABLE_BIT]     = pattern_abort_enable;
    econ[DCET_START_IRQ_ENABLE_BIT]    = start_irq_enable;
    econ[DCET_ABORT_IRQ_ENABLE_BIT]    = abort_irq_enable;
  end

  // alias decode: direct, clear, set and invert writes
  always_comb begin
    next_econ = econ;
    econ_wr   = 1'b1;
    unique case (bus.addr)
      DCET_OFF_ECON: next_econ = bus.wdata;
      DCET_OFF_CLR:  next_econ = econ & ~bus.wdata;
      DCET_OFF_SET:  next_econ = econ | bus.wdata;
      DCET_OFF_INV:  next_econ = econ ^ bus.wdata;
      default:       econ_wr   = 1'b0;
    endcase
    econ_wr   = econ_wr && bus.wr;
    next_econ = next_econ & DCET_ECON_MASK;
  end

  // control fields; set alias sets, clear alias ignores the strobe bits
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      abort_irq_select     <= DCET_ECON_RESET[DCET_AIRQ_LSB +: 8];
      start_irq_select     <= DCET_ECON_RESET[DCET_SIRQ_LSB +: 8];
      pattern_abort_enable <= DCET_ECON_RESET[DCET_PATTERN_ABORT_ENABLE_BIT];
      start_irq_enable     <= DCET_ECON_RESET[DCET_START_IRQ_ENABLE_BIT];
      abort_irq_enable     <= DCET_ECON_RESET[DCET_ABORT_IRQ_ENABLE_BIT];
    end else if (econ_wr) begin
      abort_irq_select     <= next_econ[DCET_AIRQ_LSB +: 8];
      start_irq_select     <= next_econ[DCET_SIRQ_LSB +: 8];
      pattern_abort_enable <= next_econ[DCET_PATTERN_ABORT_ENABLE_BIT];
      start_irq_enable     <= next_econ[DCET_START_IRQ_ENABLE_BIT];
      abort_irq_enable     <= next_econ[DCET_ABORT_IRQ_ENABLE_BIT];
    end
  end

  // strobe bits: only a written one acts, via the direct, set or inv alias;
  // the clear alias never starts anything since it only removes bits
  always_comb begin
    force_pulse   = 1'b0;
    swabort_pulse = 1'b0;
    if (bus.wr && bus.addr != DCET_OFF_CLR && econ_wr) begin
      force_pulse   = bus.wdata[DCET_FORCE_BIT];
      swabort_pulse = bus.wdata[DCET_ABORT_BIT];
    end
  end

  // combine triggers; pattern match only counts while enabled
  always_comb begin
    cmd.pattern_abort = pattern_abort_enable && pat_sync;
    cmd.abort         = abort_hit || swabort_pulse || cmd.pattern_abort;
    cmd.start         = (start_hit || force_pulse) && !cmd.abort;
  end

  // registered start and abort to the transfer engine; a pattern abort holds abort up while the match lasts
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      xfer_start <= 1'b0;
      xfer_abort <= 1'b0;
    end else begin
      xfer_start <= cmd.start;
      xfer_abort <= cmd.abort;
    end
  end

  // transfer tracking so the busy state is visible to software
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= DCET_IDLE;
    end else begin
      unique case (state)
        DCET_IDLE: if (cmd.start) begin
          state <= DCET_BUSY;
        end
        DCET_BUSY: if (cmd.abort || done_sync) begin
          state <= DCET_IDLE;
        end
        // codes 2 and 3 are unused; recover to idle
        default: state <= DCET_IDLE;
      endcase
    end
  end

  // abort flag: irq abort sets it, set wins over a software clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      channel_abort_flag <= 1'b0;
    end else if (abort_hit) begin
      channel_abort_flag <= 1'b1;
    end else if (bus.wr && bus.addr == DCET_OFF_CON
                 && !bus.wdata[DCET_FLAG_BIT]) begin
      channel_abort_flag <= 1'b0;
    end
  end

  // channel enable: software writes it, pattern abort clears it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      channel_enable <= 1'b0;
    end else if (cmd.pattern_abort) begin
      channel_enable <= 1'b0;
    end else if (bus.wr && bus.addr == DCET_OFF_CON) begin
      channel_enable <= bus.wdata[DCET_CHANNEL_ENABLE_BIT];
    end
  end

  // read port: data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (bus.rd) begin
      unique case (bus.addr)
        DCET_OFF_ECON: rdata <= econ;
        DCET_OFF_CON: begin
          rdata <= '0;
          rdata[DCET_CHANNEL_ENABLE_BIT] <= channel_enable;
          rdata[DCET_FLAG_BIT] <= channel_abort_flag;
        end
        DCET_OFF_STAT: rdata <= {30'h0000_0000, state == DCET_BUSY,
                                 channel_abort_flag};
        default:       rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule : dcet_top
`default_nettype wire

// ===== test/dcet_properties.sv
// checker: port-level properties of the event trigger block
`timescale 1ns/1ps
`default_nettype none
module dcet_properties
  import dcet_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        xfer_start,
  input wire logic        xfer_abort,
  input wire logic        channel_enable,
  input wire logic        channel_abort_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // a write that clears the abort flag through the channel control word
  logic flag_clr_wr;
  assign flag_clr_wr = wr && addr == DCET_OFF_CON && !wdata[0];
  // strobe bits act through word, set and invert places, never clear
  sequence s_act_wr(b);
    wr && addr[7:4] == 4'h0 && addr[1:0] == 2'h0 && addr != DCET_OFF_CLR
      && wdata[b];
  endsequence
  a_force_start: assert property (s_act_wr(7) |-> ##1 (xfer_start || xfer_abort))
    else $error("forced start missing");
  a_soft_abort: assert property (s_act_wr(6) |-> ##1 xfer_abort)
    else $error("software abort missing");
  a_unused_bits: assert property (rd && addr == DCET_OFF_ECON |=>
    rdata[31:24] == 8'h00 && rdata[7:6] == 2'h0 && rdata[2:0] == 3'h0)
    else $error("reserved or strobe bits read nonzero");
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_start_single: assert property (xfer_start && !$past(wr) |=> !xfer_start)
    else $error("start longer than one cycle");
  a_abort_wins: assert property (xfer_abort |-> !xfer_start)
    else $error("start beside abort");
  a_flag_sticky: assert property ($fell(channel_abort_flag) |-> $past(flag_clr_wr))
    else $error("abort flag dropped by itself");
  a_flag_cause: assert property ($rose(channel_abort_flag) |-> xfer_abort || $past(xfer_abort))
    else $error("abort flag without abort");
  a_pattern_drop: assert property ($fell(channel_enable) && !$past(wr) |-> xfer_abort)
    else $error("enable dropped without abort");
endmodule : dcet_properties
bind dcet_top dcet_properties u_props (.clock(clock), .sys_rst(sys_rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .xfer_start(xfer_start), .xfer_abort(xfer_abort),
  .channel_enable(channel_enable), .channel_abort_flag(channel_abort_flag));
`default_nettype wire

// ===== test/dcet_partner.sv
// partner: irq sources, pattern detector and transfer engine
`timescale 1ns/1ps
`default_nettype none
module dcet_partner #(
  parameter int DONE_CYC = 5
) (
  input  wire logic       clock,
  input  wire logic       fire,
  input  wire logic [7:0] fire_num,
  input  wire logic       fire_pat,
  input  wire logic       xfer_start,
  output logic [255:0]    irq_lines,
  output logic            pattern_match,
  output logic            transfer_done
);
  int hold_cnt;
  int run_cnt;
  initial begin
    irq_lines = '0;
    pattern_match = 1'b0;
    transfer_done = 1'b0;
    hold_cnt = 0;
    run_cnt = 0;
  end
  // requests stay up three cycles so the two-flop sync cannot miss them
  always @(posedge clock) begin
    if (fire) irq_lines <= 256'h1 << fire_num;
    if (fire_pat) pattern_match <= 1'b1;
    hold_cnt <= (fire || fire_pat) ? 3 : (hold_cnt > 0 ? hold_cnt - 1 : 0);
    if (hold_cnt == 1) irq_lines <= '0;
    if (hold_cnt == 1) pattern_match <= 1'b0;
    // engine finishes a started transfer after a fixed run
    if (xfer_start) run_cnt <= DONE_CYC;
    else if (run_cnt > 0) run_cnt <= run_cnt - 1;
    transfer_done <= (run_cnt == 1);
  end
endmodule : dcet_partner
`default_nettype wire

// ===== test/testbench.sv
// testbench: register access, irq triggers and pattern abort
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dcet_pkg::*;
  logic clock, sys_rst, wr, rd, fire, fire_pat;
  logic [7:0] addr, fire_num;
  logic [31:0] wdata, rdata;
  logic [255:0] irq_lines;
  logic pattern_match, transfer_done, xfer_start, xfer_abort;
  logic channel_enable, channel_abort_flag;
  int fails, total_checks, n_start, n_abort, s0, a0;
  logic [31:0] cw [6] = '{32'h0000_FF10, 32'h0000_FF10, 32'h0000_FF08,
                          32'h0000_FF08, 32'h0009_0918, 32'h0000_FF18};
  logic [7:0] num [6] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h09, 8'h07};
  logic [1:0] ex [6] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0};
  dcet_top DUT (.clock(clock), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq_lines(irq_lines),
    .pattern_match(pattern_match), .transfer_done(transfer_done),
    .xfer_start(xfer_start), .xfer_abort(xfer_abort),
    .channel_enable(channel_enable), .channel_abort_flag(channel_abort_flag));
  dcet_partner u_far (.clock(clock), .fire(fire), .fire_num(fire_num),
    .fire_pat(fire_pat), .xfer_start(xfer_start), .irq_lines(irq_lines),
    .pattern_match(pattern_match), .transfer_done(transfer_done));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // count every cycle that carries a start or an abort
  always @(posedge clock) begin
    if (xfer_start) n_start++;
    if (xfer_abort) n_abort++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    // read data stand only in the cycle right after the strobe
    #1 check(rdata, exp);
  endtask : rd_reg
  // deltas of starts and aborts since the last call, after things settle
  task automatic counts(input int ds, input int da);
    repeat (12) @(posedge clock);
    check(32'(n_start - s0), 32'(ds));
    check(32'(n_abort - a0), 32'(da));
    s0 = n_start;
    a0 = n_abort;
  endtask : counts
  task automatic kick(input logic p, input logic [7:0] n);
    @(posedge clock);
    fire <= !p;
    fire_pat <= p;
    fire_num <= n;
    @(posedge clock);
    fire <= 1'b0;
    fire_pat <= 1'b0;
  endtask : kick
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  initial begin
    {sys_rst, wr, rd, fire, fire_pat} = 5'h10;
    {addr, fire_num, wdata} = '0;
    {fails, total_checks, n_start, n_abort, s0, a0} = '0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd_reg(8'h00, 32'h00FF_FF00);
    wr_reg(8'h00, 32'hFFFF_FFFF);
    rd_reg(8'h00, 32'h00FF_FF38);
    counts(0, 1);
    wr_reg(8'h04, 32'h00FF_FFF8);
    rd_reg(8'h00, 32'h0000_0000);
    counts(0, 0);
    wr_reg(8'h08, 32'h0012_0040);
    counts(0, 1);
    wr_reg(8'h0C, 32'h0013_0080);
    counts(1, 0);
    rd_reg(8'h20, 32'h0000_0000);
    rd_reg(8'h00, 32'h0001_0000);
    wr_reg(8'h00, 32'h0000_0000);
    counts(0, 0);
    rd_reg(8'h40, 32'h0000_0000);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      wr_reg(8'h00, cw[i]);
      rd_reg(8'h00, cw[i]);
      kick(1'b0, num[i]);
      counts(ex[i][1], ex[i][0]);
    end
    check(32'(channel_abort_flag), 32'h1);
    rd_reg(8'h20, 32'h0000_0001);
    wr_reg(8'h10, 32'h0000_0080);
    rd_reg(8'h10, 32'h0000_0080);
    $display("test irq triggers done");
    wr_reg(8'h00, 32'h0000_0020);
    kick(1'b1, 8'h00);
    counts(0, 3);
    check(32'(channel_enable), 32'h0);
    wr_reg(8'h10, 32'h0000_0080);
    wr_reg(8'h00, 32'h0000_0000);
    kick(1'b1, 8'h00);
    counts(0, 0);
    check(32'(channel_enable), 32'h1);
    $display("test pattern abort done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
